// [verif/fault_mask_pg_tree_select_bench.sv]
// Self-checking bench for fault masking, power-good trees and interrupt
`timescale 1ns/1ps
`default_nettype none
module fault_mask_pg_tree_select_bench;
   logic clk_in = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h0, rdat;
   logic [31:0] dw = 32'h0;
   logic [15:0] src = 16'hffff; // Sources in {tree b, tree a} order
   logic [4:0] flt = 5'h0; // Faults in mask bit order
   wire [31:0] dr;
   wire ack, err, shut, pg1, pg4, irq;
   int n_mismatch = 0, n_tests = 0;
   always #2 clk_in = ~clk_in;
   fault_mask_pg_tree_select u_dut (.clk_in(clk_in), .rst_n_in(rst_n), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(dw),
      .wb_dat_out(dr), .wb_ack_out(ack), .wb_err_out(err), .linreg_2_pg_in(src[7]),
      .load_switch_a_pg_in(src[6]), .step_down_pg_in(src[5:0]), .term_linreg_pg_in(src[11]),
      .load_switch_b2_pg_in(src[10]), .load_switch_b1_pg_in(src[9]), .linreg_3_pg_in(src[8]),
      .ctrl_pin_5_in(src[15]), .ctrl_pin_4_in(src[14]), .ctrl_pin_2_in(src[13]),
      .ctrl_pin_1_in(src[12]), .linreg_1_fault_in(flt[4]), .term_linreg_fault_in(flt[3]),
      .load_switch_b2_fault_in(flt[2]), .load_switch_b1_fault_in(flt[1]),
      .linreg_3_fault_in(flt[0]), .shutdown_req_out(shut), .pg_out_1_out(pg1),
      .pg_out_4_out(pg4), .irq_out(irq));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   // Request held until ack is sampled; read data taken at that edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dw <= {24'h0, d};
      @(posedge clk_in);
      while (ack !== 1'b1) @(posedge clk_in);
      rdat = dr[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic rc(input string what, input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h0);
      chk(what, exp, rdat);
   endtask
   // Pins take three edges to reach the outputs
   task automatic settle;
      repeat (4) @(posedge clk_in);
   endtask
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (4) @(posedge clk_in);
      rst_n <= 1'b1;
      @(posedge clk_in);
   endtask
   task automatic t_reset;
      rc("mask", 8'ha3, 8'hff);
      rc("out1 a", 8'ha4, 8'hc2);
      rc("out1 b", 8'ha5, 8'haf);
      rc("out4 a", 8'ha6, 8'h00);
      rc("out4 b", 8'ha7, 8'h00);
      rc("unmapped", 8'h10, 8'h00);
      bus(1'b1, 8'ha3, 8'h00);
      rc("mask rsvd", 8'ha3, 8'he0);
      chk("pg1 all good", 8'h1, {7'h0, pg1});
      chk("pg4 all good", 8'h1, {7'h0, pg4});
      $display("reset test done");
   endtask
   // One source bad: sole member of tree 1, sole exclusion of tree 4
   task automatic t_tree;
      logic [15:0] one;
      for (int i = 0; i < 16; i++) begin
         one = 16'h1 << i;
         bus(1'b1, 8'ha4, ~one[7:0]);
         bus(1'b1, 8'ha5, ~one[15:8]);
         bus(1'b1, 8'ha6, one[7:0]);
         bus(1'b1, 8'ha7, one[15:8]);
         src <= ~one;
         settle;
         chk("pg1 bad", 8'h0, {7'h0, pg1});
         chk("pg4 excluded", 8'h1, {7'h0, pg4});
      end
      bus(1'b1, 8'ha7, 8'h00);
      settle;
      chk("pg4 bad", 8'h0, {7'h0, pg4});
      rc("status falls", 8'hb0, 8'h06);
      $display("tree test done");
   endtask
   // Each rail unmasked alone; interrupt raised, masked, cleared
   task automatic t_fault;
      for (int i = 0; i < 5; i++) begin
         do_reset;
         flt <= 5'h1f;
         settle;
         chk("reset masks", 8'h0, {7'h0, shut});
         flt <= ~(5'h1 << i);
         settle;
         bus(1'b1, 8'hb1, 8'h01);
         bus(1'b1, 8'ha3, ~(8'h1 << i));
         settle;
         chk("masked", 8'h0, {7'h0, shut});
         flt <= 5'h1f;
         settle;
         chk("unmasked", 8'h1, {7'h0, shut});
         chk("irq", 8'h1, {7'h0, irq});
         rc("pins", 8'hb2, 8'h03);
         bus(1'b1, 8'hb1, 8'h00);
         chk("irq masked", 8'h0, {7'h0, irq});
         rc("status", 8'hb0, 8'h01);
         bus(1'b1, 8'hb1, 8'h01);
         chk("irq cleared", 8'h0, {7'h0, irq});
      end
      $display("fault test done");
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      do_reset;
      t_reset;
      t_tree;
      t_fault;
      give_verdict;
   end
   // Tests need about five hundred cycles
   initial begin
      repeat (20000) @(posedge clk_in);
      n_mismatch++;
      give_verdict;
   end
endmodule // fault_mask_pg_tree_select_bench
`default_nettype wire

// [verif/pg_tree_chk.sv]
// Bus and shutdown checks on the fault mask and power-good tree block
`timescale 1ns/1ps
`default_nettype none
module pg_tree_chk (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic wb_err_out,
   input wire logic shutdown_req_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Taken request; its answer is judged one edge later
   wire req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   wire rd = req && !wb_we_in;
   ack_next_a:
      assert property (req |=> wb_ack_out) else $error("no ack");
   ack_once_a:
      assert property (wb_ack_out |=> !wb_ack_out) else $error("long ack");
   ack_idle_a:
      assert property (!wb_stb_in && !wb_ack_out |=> !wb_ack_out) else $error("stray ack");
   err_low_a:
      assert property (!wb_err_out) else $error("error raised");
   high_zero_a:
      assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0) else $error("high bits set");
   rsvd_ones_a:
      assert property (rd && wb_adr_in == 8'ha3 |=> wb_dat_out[7:5] == 3'h7)
      else $error("reserved bits");
   unmapped_zero_a:
      assert property (rd && wb_adr_in < 8'ha3 |=> wb_dat_out[7:0] == 8'h0)
      else $error("unmapped data");
   shut_hold_a:
      assert property (shutdown_req_out |=> shutdown_req_out) else $error("shutdown dropped");
endmodule // pg_tree_chk
bind fault_mask_pg_tree_select pg_tree_chk u_chk (.*);
`default_nettype wire

// [verilog/fault_mask_pg_tree_select.v]
// Fault shutdown masking and power-good trees of outputs 1 and 4, Wishbone slave
//
// Contract
// - Fault mask b bits 4..0 select five rails
// - Mask 0 lets fault shut down; 1 ignores
// - Fault mask b resets to 3f; the code reads back ff, as reserved bits 7..5 read as ones
// - Tree bit 0 includes source, 1 excludes
// - Tree a bits: linreg_2, switch_a, step_down 6..1
// - Tree b bits: pins 5,4,2,1, then four rails
// - Output 1 tree a resets to c2
// - Output 1 tree b resets to af
// - Output 4 has own identical tree pair
// - Output 4 tree a resets to 00
// - Output 4 tree b resets to 00
`timescale 1ns/1ps
`default_nettype none
`include "pg_tree_consts.vh"
module fault_mask_pg_tree_select (
   input wire clk_in,
   input wire rst_n_in,
   // Classic Wishbone slave
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [7:0] wb_adr_in,
   input wire [3:0] wb_sel_in,
   input wire [31:0] wb_dat_in,
   output reg [31:0] wb_dat_out,
   output reg wb_ack_out,
   output wire wb_err_out,
   // Rail power-good, from the analog side (asynchronous)
   input wire linreg_2_pg_in,
   input wire load_switch_a_pg_in,
   input wire [5:0] step_down_pg_in,
   input wire term_linreg_pg_in,
   input wire load_switch_b2_pg_in,
   input wire load_switch_b1_pg_in,
   input wire linreg_3_pg_in,
   // Control pin statuses (asynchronous)
   input wire ctrl_pin_5_in,
   input wire ctrl_pin_4_in,
   input wire ctrl_pin_2_in,
   input wire ctrl_pin_1_in,
   // Rail power faults (asynchronous)
   input wire linreg_1_fault_in,
   input wire term_linreg_fault_in,
   input wire load_switch_b2_fault_in,
   input wire load_switch_b1_fault_in,
   input wire linreg_3_fault_in,
   // Results
   output reg shutdown_req_out,
   output reg pg_out_1_out,
   output reg pg_out_4_out,
   output wire irq_out
);
   // Register file
   reg [4:0] fault_mask;
   reg [7:0] out1_tree_a;
   reg [7:0] out1_tree_b;
   reg [7:0] out4_tree_a;
   reg [7:0] out4_tree_b;
   reg [7:0] irq_mask;
   reg [`IRQ_BITS-1:0] irq_status;

   // Read mux and edge history
   reg [31:0] next_rdata;
   reg next_valid;
   reg pg1_prev;
   reg pg4_prev;

   // Pins before and after the synchroniser
   wire [20:0] pin_raw;
   wire [20:0] pin_sync;
   wire [7:0] tree_src_a;
   wire [7:0] tree_src_b;
   wire [15:0] tree_src;
   wire [4:0] fault_sync;

   // Tree and fault results
   wire [15:0] tree1_excl;
   wire [15:0] tree4_excl;
   wire tree1_good;
   wire tree4_good;
   wire [4:0] fault_live;
   wire fault_hit;

   // Bus decode
   wire bus_req;
   wire wr_low;
   wire wr_fault_mask;
   wire wr_out1_tree_a;
   wire wr_out1_tree_b;
   wire wr_out4_tree_a;
   wire wr_out4_tree_b;
   wire wr_irq_mask;
   wire [`IRQ_BITS-1:0] irq_event;
   wire status_read;

   // Mask reset byte cut to the five stored bits; the top three are not flops
   localparam [7:0] FAULT_MASK_RST_BYTE = `RST_FAULT_MASK_B;
   localparam [4:0] FAULT_MASK_RST = FAULT_MASK_RST_BYTE[4:0];

   // All pins are outside the clock domain: two flops before use
   assign pin_raw = {
      linreg_1_fault_in,
      term_linreg_fault_in,
      load_switch_b2_fault_in,
      load_switch_b1_fault_in,
      linreg_3_fault_in,
      ctrl_pin_5_in,
      ctrl_pin_4_in,
      ctrl_pin_2_in,
      ctrl_pin_1_in,
      term_linreg_pg_in,
      load_switch_b2_pg_in,
      load_switch_b1_pg_in,
      linreg_3_pg_in,
      linreg_2_pg_in,
      load_switch_a_pg_in,
      step_down_pg_in
   };

   pin_sync #(
      .WIDTH(21)
   ) u_pin_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .async_in(pin_raw),
      .sync_out(pin_sync)
   );

   // Sources in register bit order: b register high, a register low
   assign tree_src_a = pin_sync[7:0];
   assign tree_src_b = pin_sync[15:8];
   assign tree_src = {tree_src_b, tree_src_a};
   assign fault_sync = pin_sync[20:16];

   // Exclusion vectors share the source order, so one index serves both
   assign tree1_excl = {out1_tree_b, out1_tree_a};
   assign tree4_excl = {out4_tree_b, out4_tree_a};

   // Output 1 tree
   pg_tree_eval #(
      .WIDTH(16)
   ) u_tree1 (
      .source_good_in(tree_src),
      .excl_in(tree1_excl),
      .tree_good_out(tree1_good)
   );

   // Output 4 tree, separate register pair with the same layout
   pg_tree_eval #(
      .WIDTH(16)
   ) u_tree4 (
      .source_good_in(tree_src),
      .excl_in(tree4_excl),
      .tree_good_out(tree4_good)
   );

   // A fault counts only where its mask bit is 0
   assign fault_live = fault_sync & ~fault_mask;
   assign fault_hit = |fault_live;

   // Power-good outputs from flops so tree decode glitches never reach a pin
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pg_out_1_out <= 1'b0;
         pg_out_4_out <= 1'b0;
      end else begin
         pg_out_1_out <= tree1_good;
         pg_out_4_out <= tree4_good;
      end
   end

   // Previous output levels; reset low like the outputs, so no false fall
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pg1_prev <= 1'b0;
         pg4_prev <= 1'b0;
      end else begin
         pg1_prev <= pg_out_1_out;
         pg4_prev <= pg_out_4_out;
      end
   end

   // Shutdown latches until reset since the device powers down
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         shutdown_req_out <= 1'b0;
      end else if (fault_hit) begin
         shutdown_req_out <= 1'b1;
      end
   end

   // Bus request and low byte write strobe
   assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   assign wr_low = bus_req & wb_we_in & wb_sel_in[0];

   // No error responses: unmapped addresses still ack
   assign wb_err_out = 1'b0;

   // One write enable per register; sel[0] is already in wr_low
   assign wr_fault_mask = wr_low & (wb_adr_in == `REG_FAULT_MASK_B);
   assign wr_out1_tree_a = wr_low & (wb_adr_in == `REG_OUT1_TREE_A);
   assign wr_out1_tree_b = wr_low & (wb_adr_in == `REG_OUT1_TREE_B);
   assign wr_out4_tree_a = wr_low & (wb_adr_in == `REG_OUT4_TREE_A);
   assign wr_out4_tree_b = wr_low & (wb_adr_in == `REG_OUT4_TREE_B);
   assign wr_irq_mask = wr_low & (wb_adr_in == `REG_IRQ_MASK);

   // Fault mask b: only the five rail bits are stored
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fault_mask <= FAULT_MASK_RST;
      end else if (wr_fault_mask) begin
         fault_mask <= wb_dat_in[4:0];
      end
   end

   // Output 1 tree a: rail sources
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         out1_tree_a <= `RST_OUT1_TREE_A;
      end else if (wr_out1_tree_a) begin
         out1_tree_a <= wb_dat_in[7:0];
      end
   end

   // Output 1 tree b: control pins and four rails
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         out1_tree_b <= `RST_OUT1_TREE_B;
      end else if (wr_out1_tree_b) begin
         out1_tree_b <= wb_dat_in[7:0];
      end
   end

   // Output 4 tree a: rail sources
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         out4_tree_a <= `RST_OUT4_TREE_A;
      end else if (wr_out4_tree_a) begin
         out4_tree_a <= wb_dat_in[7:0];
      end
   end

   // Output 4 tree b: control pins and four rails
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         out4_tree_b <= `RST_OUT4_TREE_B;
      end else if (wr_out4_tree_b) begin
         out4_tree_b <= wb_dat_in[7:0];
      end
   end

   // Interrupt mask, same bit layout as the status
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_mask <= `RST_IRQ_MASK;
      end else if (wr_irq_mask) begin
         irq_mask <= wb_dat_in[7:0];
      end
   end

   // New shutdown: a hit while the request is still low
   assign irq_event[`IRQ_BIT_SHUTDOWN] = fault_hit & ~shutdown_req_out;

   // Either output losing power-good
   assign irq_event[`IRQ_BIT_OUT1_FALL] = pg1_prev & ~pg_out_1_out;
   assign irq_event[`IRQ_BIT_OUT4_FALL] = pg4_prev & ~pg_out_4_out;

   // Any status read clears; writes to the status address do nothing
   assign status_read = bus_req & ~wb_we_in & (wb_adr_in == `REG_IRQ_STATUS);

   // Read clears status; a same-cycle event still sets its bit
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_status <= {`IRQ_BITS{1'b0}};
      end else if (status_read) begin
         irq_status <= irq_event;
      end else begin
         irq_status <= irq_status | irq_event;
      end
   end

   // Level interrupt: high while an unmasked status bit is set
   assign irq_out = |(irq_status & irq_mask[`IRQ_BITS-1:0]);

   // Read mux; reserved fault-mask bits read back as ones
   always @* begin
      next_rdata = 32'h00000000;
      next_valid = 1'b1;
      case (wb_adr_in)
         `REG_FAULT_MASK_B: begin
            next_rdata[7:0] = `FAULT_MASK_RSVD_BITS | {3'h0, fault_mask};
         end
         `REG_OUT1_TREE_A: begin
            next_rdata[7:0] = out1_tree_a;
         end
         `REG_OUT1_TREE_B: begin
            next_rdata[7:0] = out1_tree_b;
         end
         `REG_OUT4_TREE_A: begin
            next_rdata[7:0] = out4_tree_a;
         end
         `REG_OUT4_TREE_B: begin
            next_rdata[7:0] = out4_tree_b;
         end
         `REG_IRQ_STATUS: begin
            next_rdata[`IRQ_BITS-1:0] = irq_status;
         end
         `REG_IRQ_MASK: begin
            next_rdata[7:0] = irq_mask;
         end
         `REG_PIN_STATE: begin
            next_rdata[2:0] = {pg_out_4_out, pg_out_1_out, shutdown_req_out};
         end
         default: begin
            next_valid = 1'b0;
         end
      endcase
   end

   // One-cycle ack after each request; ack itself blocks a second take
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wb_ack_out <= 1'b0;
      end else begin
         wb_ack_out <= bus_req;
      end
   end

   // Read data from flops; unmapped reads and all writes return zero
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wb_dat_out <= 32'h00000000;
      end else if (bus_req && !wb_we_in && next_valid) begin
         wb_dat_out <= next_rdata;
      end else if (bus_req) begin
         wb_dat_out <= 32'h00000000;
      end
   end
endmodule // fault_mask_pg_tree_select
`default_nettype wire

// [verilog/pg_tree_consts.vh]
// Register map, reset values and field positions of the fault mask and power-good trees
`ifndef PG_TREE_CONSTS_VH
`define PG_TREE_CONSTS_VH
`define REG_FAULT_MASK_B 8'ha3
`define REG_OUT1_TREE_A 8'ha4
`define REG_OUT1_TREE_B 8'ha5
`define REG_OUT4_TREE_A 8'ha6
`define REG_OUT4_TREE_B 8'ha7
`define REG_IRQ_STATUS 8'hb0
`define REG_IRQ_MASK 8'hb1
`define REG_PIN_STATE 8'hb2
`define RST_FAULT_MASK_B 8'h3f
`define RST_OUT1_TREE_A 8'hc2
`define RST_OUT1_TREE_B 8'haf
`define RST_OUT4_TREE_A 8'h00
`define RST_OUT4_TREE_B 8'h00
`define RST_IRQ_MASK 8'h00
`define FAULT_MASK_WR_BITS 8'h1f
`define FAULT_MASK_RSVD_BITS 8'he0
`define IRQ_BIT_SHUTDOWN 0
`define IRQ_BIT_OUT1_FALL 1
`define IRQ_BIT_OUT4_FALL 2
`define IRQ_BITS 3
`define PIN_BIT_SHUTDOWN 0
`define PIN_BIT_OUT1 1
`define PIN_BIT_OUT4 2
`endif

// [verilog/pg_tree_eval.v]
// One power-good tree: AND of all sources not excluded
`timescale 1ns/1ps
`default_nettype none
module pg_tree_eval #(
   parameter WIDTH = 16
) (
   input wire [WIDTH-1:0] source_good_in,
   input wire [WIDTH-1:0] excl_in,
   output wire tree_good_out
);
   wire [WIDTH-1:0] term;
   genvar i;

   // Excluded bit forces its term true so it is ignored
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_term
         assign term[i] = source_good_in[i] | excl_in[i];
      end
   endgenerate

   assign tree_good_out = &term;
endmodule // pg_tree_eval
`default_nettype wire

// [verilog/pin_sync.v]
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter WIDTH = 8
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage_one;

   // First stage feeds only the second stage
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage_one <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         stage_one <= async_in;
         sync_out <= stage_one;
      end
   end
endmodule // pin_sync
`default_nettype wire
